// ---- deac_defs.vh ----
// Purpose: constants for the data eeprom access control block
// Assumes: 8-bit cpu bus, 128-byte array, 32-byte rows
// Notes:   definitions only
`ifndef DEAC_DEFS_VH
`define DEAC_DEFS_VH

`define DEAC_CSR_ADDR        16'h0030
`define DEAC_CSR_RESET       8'h00
`define DEAC_BIT_START       0
`define DEAC_BIT_WMODE       1
`define DEAC_ARR_BASE        16'h1000
`define DEAC_ARR_SPAN        16'h0080
`define DEAC_ARR_WORDS       128
`define DEAC_ROW_BYTES       32
`define DEAC_PROG_TIME_NS    5000
`define DEAC_CLK_PERIOD_NS   5
`define DEAC_PROG_CYCLES     (`DEAC_PROG_TIME_NS / `DEAC_CLK_PERIOD_NS)
`define DEAC_ERASED          8'hFF

`endif

// ---- deac_latches.v ----
// Purpose: 32 byte data latches with and-merge on repeated writes
// Assumes: clear has priority over capture
// Notes:   no cpu read port on purpose; the read port serves the commit path only
`timescale 1ns/1ps
`default_nettype none
`include "deac_defs.vh"

module deac_latches (
	// clock and reset
	input  wire         ref_clk,
	input  wire         rst_b,
	// capture side
	input  wire         cap_en,
	input  wire [4:0]   cap_idx,
	input  wire [7:0]   cap_data,
	input  wire         clr,
	// row view for the commit path
	input  wire [4:0]   rd_idx,
	output wire [7:0]   rd_data,
	output wire         rd_used
);

	reg [7:0]  byte_r [0:31];
	reg [31:0] used_r;
	integer    i;

	always @(posedge ref_clk) begin
		if (!rst_b || clr) begin
			for (i = 0; i < `DEAC_ROW_BYTES; i = i + 1)
				byte_r[i] <= 8'hFF;
			used_r <= 32'h00000000;
		end else if (cap_en) begin
			byte_r[cap_idx] <= byte_r[cap_idx] & cap_data;
			used_r[cap_idx] <= 1'b1;
		end
	end

	assign rd_data = byte_r[rd_idx];
	assign rd_used = used_r[rd_idx];

endmodule // deac_latches
`default_nettype wire

// ---- deac_array.v ----
// Purpose: byte array of the data eeprom, flip-flop storage
// Assumes: one write port, one read port, bulk erase
// Notes:   contents are kept through reset, as real cells would keep them; no reset input
`timescale 1ns/1ps
`default_nettype none
`include "deac_defs.vh"

module deac_array (
	// clock
	input  wire         ref_clk,
	// write port
	input  wire         we,
	input  wire [6:0]   waddr,
	input  wire [7:0]   wdata,
	input  wire         erase_all,
	// read port
	input  wire [6:0]   raddr,
	output wire [7:0]   rdata
);

	reg [7:0] mem_r [0:127];
	integer   i;

	always @(posedge ref_clk) begin
		if (erase_all) begin
			for (i = 0; i < `DEAC_ARR_WORDS; i = i + 1)
				mem_r[i] <= `DEAC_ERASED;
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	assign rdata = mem_r[raddr];

endmodule // deac_array
`default_nettype wire

// ---- deac_top.v ----
// Purpose: data eeprom access control: read mode, latch mode, row programming
// Assumes: cpu bus strobes one cycle long, read data one cycle later
// Notes:   programming walks 32 latch slots then waits out the timer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "deac_defs.vh"

// Operation
// - read mode returns array bytes like plain rom
// - write mode captures each byte into latch chosen by low address
// - setting program start commits all written latches to the row
// - target row comes from the last eeprom write address
// - end of programming clears start and write mode together
// - latches clear at reset, programming end, write mode fall or halt abort; writes and-merge
// - latches have no cpu read path
// - wait or active halt enters wait at once, or after programming
// - halt enters at once and aborts programming
// - array read while write mode set leaves bus undriven
// - array write while write mode clear is ignored
// - reset during programming leaves array contents unguaranteed
// - readout protection blocks array reads and rewrites
// - removing protection first erases the whole array
// - status bits 7 to 2 read zero
// - write mode cleared by software only while program start is zero
// - program start reads 1 during programming, 0 otherwise
// - status register at 0030h, resets to 00h
// - programming duration is timed internally
module deac_top #(
	parameter integer PROG_CYCLES = `DEAC_PROG_CYCLES
) (
	// clock and reset
	input  wire         ref_clk,
	input  wire         rst_b,
	// cpu bus
	input  wire [15:0]  addr,
	input  wire [7:0]   wdata,
	input  wire         wr_stb,
	input  wire         rd_stb,
	output reg  [7:0]   rdata,
	output reg          rdata_oe_b,
	// power modes
	input  wire         wait_req,
	input  wire         halt_req,
	output reg          wait_ack,
	output reg          halt_ack,
	// protection option
	input  wire         readout_prot,
	input  wire         prot_remove,
	output reg          erase_busy
);

	//--------------------------------------------------------------
	// states
	//--------------------------------------------------------------
	// one-hot: idle, copy latches into the row, wait out the timer,
	// bulk erase; any code outside these falls back to idle
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_COPY  = 4'h2;
	localparam [3:0] ST_TIMER = 4'h4;
	localparam [3:0] ST_ERASE = 4'h8;

	//--------------------------------------------------------------
	// address decode helpers
	//--------------------------------------------------------------
	// array window check, used by both the read and the write decode
	function in_array;
		input [15:0] a;
		begin
			if (a < `DEAC_ARR_BASE) begin
				in_array = 1'b0;
			end else if (a < (`DEAC_ARR_BASE + `DEAC_ARR_SPAN)) begin
				in_array = 1'b1;
			end else begin
				in_array = 1'b0;
			end
		end
	endfunction

	// control register match, used by both strobes
	function is_csr;
		input [15:0] a;
		begin
			is_csr = (a == `DEAC_CSR_ADDR);
		end
	endfunction

	// byte offset inside the array: low five bits pick the latch,
	// the two above pick the row
	function [6:0] arr_off;
		input [15:0] a;
		reg   [15:0] d;
		begin
			d = a - `DEAC_ARR_BASE;
			arr_off = d[6:0];
		end
	endfunction

	//--------------------------------------------------------------
	// registers and decode
	//--------------------------------------------------------------
	reg [3:0]  state_r;
	reg [3:0]  state_nxt;
	reg        wmode_r;
	reg        start_r;
	reg        wmode_fall_r;
	reg [1:0]  row_r;
	reg [4:0]  slot_r;
	reg [31:0] tmr_r;
	reg        halted_r;

	wire [6:0] addr_off  = arr_off(addr);
	wire       hit_arr_w = wr_stb && in_array(addr);
	wire       hit_arr_r = rd_stb && in_array(addr);
	wire       hit_csr_w = wr_stb && is_csr(addr);
	wire       hit_csr_r = rd_stb && is_csr(addr);
	wire       busy      = (state_r != ST_IDLE);
	wire       st_idle   = (state_r == ST_IDLE);
	wire       st_copy   = (state_r == ST_COPY);
	wire       st_timer  = (state_r == ST_TIMER);
	wire       st_erase  = (state_r == ST_ERASE);
	wire       slot_used;
	wire [7:0] slot_byte;
	wire [7:0] arr_rd;

	//--------------------------------------------------------------
	// events
	//--------------------------------------------------------------
	// control write in idle; a halt request in the same cycle wins
	wire csr_idle_w = st_idle && !prot_remove && hit_csr_w && !halt_req;

	// start with write mode already on, or set by the same write
	wire go_prog    = csr_idle_w && wdata[`DEAC_BIT_START] &&
		(wmode_r || wdata[`DEAC_BIT_WMODE]);
	wire mode_wr    = csr_idle_w && !go_prog;
	wire go_erase   = st_idle && prot_remove;

	// clearing the start bit mid-cycle is allowed, data not guaranteed
	wire sw_abort   = hit_csr_w && busy && !st_erase && !wdata[`DEAC_BIT_START];
	// erase is one cycle and always finishes, even under halt
	wire halt_abort = halt_req && busy && !st_erase;

	wire copy_last  = st_copy && (slot_r == 5'h1F);
	wire prog_done  = st_timer && (tmr_r == 32'h00000000);

	// a write in read mode, while running or protected never reaches the latches
	wire cap_en     = hit_arr_w && wmode_r && !start_r &&
		!readout_prot && !halted_r;
	// halt drops write mode too, so it clears the latches as a fall would
	wire slots_clr  = prog_done || wmode_fall_r || halt_abort;
	// no cell write in the cycle a halt arrives
	wire arr_we     = st_copy && slot_used && !halt_req && !halted_r;

	//--------------------------------------------------------------
	// latches and array
	//--------------------------------------------------------------
	deac_latches deac_latches_inst (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.cap_en   (cap_en),
		.cap_idx  (addr_off[4:0]),
		.cap_data (wdata),
		.clr      (slots_clr),
		.rd_idx   (slot_r),
		.rd_data  (slot_byte),
		.rd_used  (slot_used)
	);

	deac_array deac_array_inst (
		.ref_clk   (ref_clk),
		.we        (arr_we),
		.waddr     ({row_r, slot_r}),
		.wdata     (slot_byte),
		.erase_all (st_erase),
		.raddr     (addr_off),
		.rdata     (arr_rd)
	);

	//--------------------------------------------------------------
	// sequencer
	//--------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (go_erase) begin
					state_nxt = ST_ERASE;
				end else if (go_prog) begin
					state_nxt = ST_COPY;
				end
			end
			ST_COPY: begin
				if (copy_last) begin
					state_nxt = ST_TIMER;
				end
			end
			ST_TIMER: begin
				if (prog_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ERASE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// either abort drops the cycle where it stands
		if (sw_abort || halt_abort) begin
			state_nxt = ST_IDLE;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	//--------------------------------------------------------------
	// control register bits
	//--------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			wmode_r <= 1'b0;
		end else if (prog_done || halt_abort) begin
			wmode_r <= 1'b0;
		end else if (go_prog) begin
			wmode_r <= 1'b1;
		end else if (mode_wr) begin
			wmode_r <= wdata[`DEAC_BIT_WMODE];
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			start_r <= 1'b0;
		end else if (prog_done || sw_abort || halt_abort) begin
			start_r <= 1'b0;
		end else if (go_prog) begin
			start_r <= 1'b1;
		end
	end

	// the latch clear lands one cycle after write mode falls
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			wmode_fall_r <= 1'b0;
		end else begin
			wmode_fall_r <= mode_wr && wmode_r && !wdata[`DEAC_BIT_WMODE];
		end
	end

	//--------------------------------------------------------------
	// row, slot walk and timer
	//--------------------------------------------------------------
	// only the last captured write sets the row; mixed rows are not caught
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			row_r <= 2'h0;
		end else if (cap_en) begin
			row_r <= addr_off[6:5];
		end
	end

	// all 32 slots are visited; unused ones leave their cells alone
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			slot_r <= 5'h00;
		end else if (go_prog) begin
			slot_r <= 5'h00;
		end else if (st_copy) begin
			slot_r <= slot_r + 5'h01;
		end
	end

	// one count per clock, so the parameter is the cycle figure itself
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			tmr_r <= 32'h00000000;
		end else if (copy_last) begin
			tmr_r <= PROG_CYCLES;
		end else if (st_timer && (tmr_r != 32'h00000000)) begin
			tmr_r <= tmr_r - 32'h00000001;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			halted_r <= 1'b0;
		end else begin
			halted_r <= halt_req;
		end
	end

	//--------------------------------------------------------------
	// read data
	//--------------------------------------------------------------
	// the bus is driven for one cycle after a hit read and idles at zero
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			rdata      <= 8'h00;
			rdata_oe_b <= 1'b1;
		end else if (hit_csr_r) begin
			rdata      <= {6'h00, wmode_r, start_r};
			rdata_oe_b <= 1'b0;
		end else if (hit_arr_r && !wmode_r && !readout_prot) begin
			rdata      <= arr_rd;
			rdata_oe_b <= 1'b0;
		end else begin
			// write mode, protection or a miss: bus left undriven
			rdata      <= 8'h00;
			rdata_oe_b <= 1'b1;
		end
	end

	//--------------------------------------------------------------
	// power modes and erase flag
	//--------------------------------------------------------------
	// wait is only granted idle, so a running cycle always finishes first
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			wait_ack <= 1'b0;
		end else begin
			wait_ack <= wait_req && !busy;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			halt_ack <= 1'b0;
		end else begin
			halt_ack <= halt_req;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			erase_busy <= 1'b0;
		end else begin
			erase_busy <= st_erase || prot_remove;
		end
	end

endmodule // deac_top
`default_nettype wire

// ---- deac_checker.sv ----
// Purpose: port checks for deac_top
// Assumes: csr at 0030h, array at 1000h-107Fh
// Notes:   latch state is not visible at the ports
`timescale 1ns/1ps
`default_nettype none
module deac_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// cpu bus
	input wire logic [15:0] addr,
	input wire logic        rd_stb,
	input wire logic [7:0]  rdata,
	input wire logic        rdata_oe_b,
	// modes
	input wire logic        wait_req,
	input wire logic        wait_ack,
	input wire logic        halt_req,
	input wire logic        halt_ack,
	input wire logic        readout_prot
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence csr_rd;
		rd_stb && addr == 16'h0030;
	endsequence
	sequence arr_rd;
		rd_stb && addr[15:7] == 9'h020;
	endsequence
	chk_csr_answer:
	assert property (csr_rd |=> !rdata_oe_b && rdata[7:2] == 6'h00) else $error("csr read");
	chk_prot_read:
	assert property (arr_rd and readout_prot |=> rdata_oe_b) else $error("protected read");
	chk_unmapped_rd:
	assert property (rd_stb && addr != 16'h0030 && addr[15:7] != 9'h020 |=> rdata_oe_b)
		else $error("unmapped read");
	chk_oe_cause:
	assert property (!rdata_oe_b |-> $past(rd_stb)) else $error("bus driven unasked");
	chk_idle_zero:
	assert property (rdata_oe_b |-> rdata == 8'h00) else $error("data while undriven");
	chk_halt_enter:
	assert property (halt_req |=> halt_ack) else $error("halt late");
	chk_halt_leave:
	assert property (!halt_req |=> !halt_ack) else $error("halt stuck");
	chk_wait_leave:
	assert property (!wait_req |=> !wait_ack) else $error("wait stuck");
endmodule // deac_checker
bind deac_top deac_checker deac_checker_inst (.ref_clk, .rst_b, .addr, .rd_stb, .rdata,
	.rdata_oe_b, .wait_req, .wait_ack, .halt_req, .halt_ack, .readout_prot);
`default_nettype wire

// ---- deac_cpu_model.sv ----
// Purpose: cpu bus master for deac_top
// Assumes: one-cycle strobes, read data one cycle later
// Notes:   released lines show the inverse so stale values never match
`timescale 1ns/1ps
`default_nettype none
module deac_cpu_model (
	// clock
	input wire logic        ref_clk,
	// cpu bus
	output var logic [15:0] addr = 16'h0000,
	output var logic [7:0]  wdata = 8'h00,
	output var logic        wr_stb = 1'b0,
	output var logic        rd_stb = 1'b0,
	input wire logic [7:0]  rdata,
	input wire logic        rdata_oe_b
);
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		addr <= ~a;
		wdata <= ~v;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v, output logic ob);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		addr <= ~a;
		@(negedge ref_clk);
		v = rdata;
		ob = rdata_oe_b;
	endtask
endmodule // deac_cpu_model
`default_nettype wire

// ---- deac_top_tb.sv ----
// Purpose: register-level tests of deac_top
// Assumes: programming time shortened to 4 cycles
// Notes:   array is erased first since it powers up unknown
`timescale 1ns/1ps
`default_nettype none
module deac_top_tb;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, d;
	logic        wr_stb, rd_stb, rdata_oe_b, ob, wait_ack, halt_ack, erase_busy;
	logic        wait_req = 1'b0, halt_req = 1'b0, readout_prot = 1'b0, prot_remove = 1'b0;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	deac_top #(.PROG_CYCLES(4)) deac_top_inst (.ref_clk, .rst_b, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .rdata_oe_b, .wait_req, .halt_req, .wait_ack, .halt_ack,
		.readout_prot, .prot_remove, .erase_busy);
	deac_cpu_model deac_cpu_model_inst (.ref_clk, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.rdata_oe_b);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		deac_cpu_model_inst.wr(a, v);
	endtask
	task automatic start_row(input logic [15:0] a, input logic [7:0] v);
		wr(16'h0030, 8'h02);
		wr(a, v);
		wr(16'h0030, 8'h03);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic eo);
		deac_cpu_model_inst.rd(a, d, ob);
		chk("oe_b", {7'h00, ob}, {7'h00, eo});
		chk("rdata", d, e);
	endtask
	// poll until the busy pair clears; a 02h would mean the bits fell apart
	task automatic wait_done;
		for (int i = 0; i < 60; i++) begin
			deac_cpu_model_inst.rd(16'h0030, d, ob);
			if (d !== 8'h03)
				break;
		end
		chk("csr end", d, 8'h00);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(16'h0030, 8'h00, 1'b0);
		@(posedge ref_clk) prot_remove <= 1'b1;
		@(posedge ref_clk) prot_remove <= 1'b0;
		@(negedge ref_clk);
		for (int i = 0; i < 50 && erase_busy !== 1'b0; i++)
			@(negedge ref_clk);
		chk("erase_busy", {7'h00, erase_busy}, 8'h00);
		rdc(16'h1005, 8'hFF, 1'b0);
		$display("erase test done");
		wr(16'h0030, 8'hFE);
		rdc(16'h0030, 8'h02, 1'b0);
		rdc(16'h1021, 8'h00, 1'b1);
		// one row only between program starts
		wr(16'h1021, 8'h5A);
		wr(16'h1021, 8'h0F);
		wr(16'h1022, 8'h33);
		wr(16'h0030, 8'h03);
		rdc(16'h0030, 8'h03, 1'b0);
		wait_done();
		rdc(16'h1021, 8'h0A, 1'b0);
		rdc(16'h1022, 8'h33, 1'b0);
		rdc(16'h1020, 8'hFF, 1'b0);
		$display("program test done");
		wr(16'h0030, 8'h02);
		wr(16'h1023, 8'hF0);
		wr(16'h0030, 8'h00);
		wr(16'h0030, 8'h02);
		wr(16'h1024, 8'h3C);
		wr(16'h0030, 8'h03);
		wait_done();
		rdc(16'h1023, 8'hFF, 1'b0);
		rdc(16'h1024, 8'h3C, 1'b0);
		wr(16'h1022, 8'h00);
		rdc(16'h1022, 8'h33, 1'b0);
		@(posedge ref_clk) readout_prot <= 1'b1;
		rdc(16'h1022, 8'h00, 1'b1);
		@(posedge ref_clk) readout_prot <= 1'b0;
		rdc(16'h2000, 8'h00, 1'b1);
		$display("access test done");
		// code runs outside the array throughout, so array writes are safe
		start_row(16'h1040, 8'h11);
		wr(16'h0030, 8'h01);
		rdc(16'h0030, 8'h03, 1'b0);
		@(posedge ref_clk) wait_req <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("wait_ack busy", {7'h00, wait_ack}, 8'h00);
		wait_done();
		chk("wait_ack idle", {7'h00, wait_ack}, 8'h01);
		@(posedge ref_clk) wait_req <= 1'b0;
		rdc(16'h1040, 8'h11, 1'b0);
		start_row(16'h1060, 8'h22);
		@(posedge ref_clk) halt_req <= 1'b1;
		@(posedge ref_clk) halt_req <= 1'b0;
		@(negedge ref_clk);
		chk("halt_ack abort", {7'h00, halt_ack}, 8'h01);
		rdc(16'h0030, 8'h00, 1'b0);
		start_row(16'h1000, 8'h44);
		@(posedge ref_clk) rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(16'h0030, 8'h00, 1'b0);
		$display("abort test done");
		@(posedge ref_clk) wait_req <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("wait_ack", {7'h00, wait_ack}, 8'h01);
		@(posedge ref_clk) wait_req <= 1'b0;
		halt_req <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("halt_ack", {7'h00, halt_ack}, 8'h01);
		@(posedge ref_clk) halt_req <= 1'b0;
		$display("power test done");
		give_verdict();
	end
endmodule // deac_top_tb
`default_nettype wire
